/* File: hw/dpm_program_map.sv */
// program map: fetch and table address forming, partition choice, register slave
//
// Overview of operation
// [R1] program addresses are 24 bits, from the 23-bit pc or table operations
// [R2] user accesses stay in the lower half unless table page top bit is set
// [R3] one single and two dual modes; table access never stalls fetch
// [R4] write block is 128 instruction words, erase block 1024 words
// [R5] even address gives lower word, odd gives upper word with top byte zero
// [R6] fetch addresses are even and step by two
// [R7] single mode maps user memory contiguously from address zero
// [R8] dual modes split memory in two; only the active partition executes
// [R9] active partition sits at logical zero, inactive at the upper base
// [R10] at reset, dual mode activates the lower boot sequence; single ignores it
// [R11] new boot sequence values only act after the next reset
// [R12] equal or both corrupted sequences select partition one
// [R13] exactly one corrupted sequence selects the intact partition
// [R14] invalid sequence numbers count as the highest value before comparing
// [R15] swap instruction exchanges partitions, keeping the reset-time choice
// [R16] status bit reads one when partition two is active
// [R17] addresses below 000200h hold fixed vectors; software places the jump
// [R18] primary vector table spans 000004h to 0000ffh
// [R19] alternate table at (boot segment limit minus one) times 0x800 when enabled
// [R20] boot sequence word is read as a full 24-bit value
// [R21] boot segment follows the vector area, general segment follows it
// [R22] partition choice is resolved once in reset, before the first fetch
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module dpm_program_map
   import dpm_pkg::*;
(
   input  wire logic        MCLK,
   input  wire logic        RST,
   input  wire dpm_cfg_t    CFG,
   input  wire logic        CFG_DONE,
   input  wire logic        PARTITION_SWAP_INSTRUCTION,
   input  wire dpm_fop_t    FETCH_OP,
   input  wire logic [22:0] FETCH_PC,
   input  wire dpm_tbl_t    TBL,
   input  wire logic [23:0] FLASH_DATA,
   output logic             FETCH_READY,
   output logic             FETCH_VALID,
   output logic [23:0]      FETCH_ADDR,
   output logic             FETCH_ERR,
   output logic             FETCH_VECTOR,
   output logic             FETCH_IVT,
   output logic             FETCH_BOOTSEG,
   output logic             TBL_STROBE,
   output logic             TBL_WR,
   output logic [23:0]      TBL_ADDR,
   output logic             TBL_CFG,
   output logic             TBL_UPPER,
   output logic [23:0]      TBL_ROW,
   output logic [23:0]      TBL_PAGE,
   output logic [15:0]      TBL_RDATA,
   output logic             TBL_RVALID,
   output logic             SECOND_PARTITION_ACTIVE_FLAG,
   output logic [23:0]      ALTERNATE_VECTOR_TABLE_BASE,
   output logic             ALTERNATE_VECTOR_TABLE_EN,
   input  wire logic [31:0] AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   input  wire logic [31:0] ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY
);

   dpm_state_t  state;
   dpm_cfg_t    cfg_q;
   logic        reset_sel;
   logic [22:0] ptr;
   logic [22:0] next_ptr;
   logic [7:0]  table_page_register;
   logic        rd_pend;
   logic        aw_held;
   logic        w_held;
   logic [31:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;

   // logical address into physical: in dual modes bit 22 picks active or inactive
   function automatic logic [23:0] to_phys(input logic [23:0] a, input logic dual, input logic act);
      to_phys = a;
      if (dual && !a[23]) begin
         to_phys[22] = a[22] ^ act;
      end
   endfunction

   // ---------------- partition choice ----------------
   wire        dual_q  = (cfg_q.mode == MODE_DUAL) || (cfg_q.mode == MODE_DUAL_PROT);  // [R3]
   // the whole 24-bit word is checked; any upper bit set marks it unusable
   wire        ok1     = cfg_q.seq1_ok && (cfg_q.seq1[23:12] == 12'h000);  // [R20]
   wire        ok2     = cfg_q.seq2_ok && (cfg_q.seq2[23:12] == 12'h000);  // [R20]
   wire [11:0] eff1    = ok1 ? cfg_q.seq1[11:0] : SEQ_MAX;  // [R14]
   wire [11:0] eff2    = ok2 ? cfg_q.seq2[11:0] : SEQ_MAX;  // [R14]
   wire        bad1_only = ok2 && !ok1;
   wire        bad2_only = ok1 && !ok2;
   // equal values fall through to partition one
   wire        pick_p2 = dual_q && (bad1_only || (!bad2_only && (eff2 < eff1)));  // [R10] [R12] [R13]

   wire        running = (state == ST_RUN);
   wire        do_swap = running && dual_q && PARTITION_SWAP_INSTRUCTION;  // [R15]

   always_ff @(posedge MCLK) begin
      if (RST) begin
         state <= ST_LOAD;
      end else begin
         case (state)
            ST_LOAD:    state <= CFG_DONE ? ST_RESOLVE : ST_LOAD;
            ST_RESOLVE: state <= ST_RUN;  // [R22]
            ST_RUN:     state <= ST_RUN;
            default:    state <= ST_LOAD;
         endcase
      end
   end

   // configuration is caught only while loading, so later reprogramming waits for reset
   always_ff @(posedge MCLK) begin
      if (RST) begin
         cfg_q <= '0;
      end else if (state == ST_LOAD && CFG_DONE) begin
         cfg_q <= CFG;  // [R11] [R22]
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         reset_sel                    <= 1'b0;
         SECOND_PARTITION_ACTIVE_FLAG <= 1'b0;
      end else if (state == ST_RESOLVE) begin
         reset_sel                    <= pick_p2;  // [R10] [R22]
         SECOND_PARTITION_ACTIVE_FLAG <= pick_p2;  // [R16]
      end else if (do_swap) begin
         SECOND_PARTITION_ACTIVE_FLAG <= !SECOND_PARTITION_ACTIVE_FLAG;  // [R15] [R16]
      end
   end

   wire active = SECOND_PARTITION_ACTIVE_FLAG;

   // ---------------- boot segment and vector tables ----------------
   wire        bs_present = (cfg_q.boot_segment_limit != 13'h0000);
   wire [23:0] alternate_vector_table_calc  = 24'(cfg_q.boot_segment_limit - 13'h0001) * ALTERNATE_VECTOR_TABLE_STEP;  // [R19]
   wire [23:0] gs_base    = 24'(cfg_q.boot_segment_limit) * ALTERNATE_VECTOR_TABLE_STEP;  // [R21]

   always_ff @(posedge MCLK) begin
      if (RST) begin
         ALTERNATE_VECTOR_TABLE_BASE <= 24'h000000;
         ALTERNATE_VECTOR_TABLE_EN   <= 1'b0;
      end else begin
         ALTERNATE_VECTOR_TABLE_BASE <= bs_present ? alternate_vector_table_calc : 24'h000000;  // [R19]
         ALTERNATE_VECTOR_TABLE_EN   <= running && bs_present && !cfg_q.alternate_vector_table_dis;  // [R19]
      end
   end

   // ---------------- instruction fetch ----------------
   always_comb begin
      case (FETCH_OP)
         FOP_LOAD: next_ptr = {FETCH_PC[PC_W-1:1], 1'b0};  // [R1] [R6]
         FOP_INC:  next_ptr = ptr + 23'h000002;  // [R6]
         FOP_DEC:  next_ptr = ptr - 23'h000002;  // [R6]
         default:  next_ptr = ptr;
      endcase
   end

   // pc is 23 bits, so fetches can never reach the upper half
   wire [23:0] fetch_log  = {1'b0, next_ptr};  // [R1] [R2]
   wire        fetch_go   = running && (FETCH_OP != FOP_NONE);  // [R22]
   wire        fetch_inac = dual_q && fetch_log[22];  // [R8]
   wire        in_vec     = fetch_log < VECTOR_END;  // [R17]
   wire        in_ivt     = (fetch_log >= IVT_FIRST) && (fetch_log <= IVT_LAST);  // [R18]
   wire        in_bs      = bs_present && !in_vec && (fetch_log < gs_base);  // [R21]

   always_ff @(posedge MCLK) begin
      if (RST) begin
         ptr           <= 23'h000000;
         FETCH_READY   <= 1'b0;
         FETCH_VALID   <= 1'b0;
         FETCH_ADDR    <= ACTIVE_BASE;
         FETCH_ERR     <= 1'b0;
         FETCH_VECTOR  <= 1'b0;
         FETCH_IVT     <= 1'b0;
         FETCH_BOOTSEG <= 1'b0;
      end else begin
         FETCH_READY <= (state == ST_RESOLVE) || running;  // [R22]
         FETCH_VALID <= fetch_go;
         if (fetch_go) begin
            ptr           <= next_ptr;
            FETCH_ADDR    <= to_phys(fetch_log, dual_q, active);  // [R7] [R9]
            FETCH_ERR     <= fetch_inac;  // [R8]
            FETCH_VECTOR  <= in_vec;  // [R17]
            FETCH_IVT     <= in_ivt;  // [R18]
            FETCH_BOOTSEG <= in_bs;  // [R21]
         end
      end
   end

   // ---------------- table access ----------------
   // runs beside fetch every cycle, so programming the inactive half never stalls
   wire [23:0] tbl_log  = {table_page_register, TBL.offset};  // [R1]
   wire        tbl_cfg  = table_page_register[CFG_PAGE_BIT];  // [R2]
   wire [23:0] tbl_phys = to_phys(tbl_log, dual_q, active);  // [R9]
   wire        tbl_go   = running && TBL.valid;  // [R3]

   always_ff @(posedge MCLK) begin
      if (RST) begin
         TBL_STROBE <= 1'b0;
         TBL_WR     <= 1'b0;
         TBL_ADDR   <= 24'h000000;
         TBL_CFG    <= 1'b0;
         TBL_UPPER  <= 1'b0;
         TBL_ROW    <= 24'h000000;
         TBL_PAGE   <= 24'h000000;
         rd_pend    <= 1'b0;
         TBL_RVALID <= 1'b0;
         TBL_RDATA  <= 16'h0000;
      end else begin
         TBL_STROBE <= tbl_go;
         rd_pend    <= tbl_go && !TBL.write;
         TBL_RVALID <= rd_pend;
         if (tbl_go) begin
            TBL_WR    <= TBL.write;
            TBL_ADDR  <= tbl_phys;
            TBL_CFG   <= tbl_cfg;  // [R2]
            TBL_UPPER <= tbl_log[0];  // [R5]
            TBL_ROW   <= tbl_phys & ROW_MASK;  // [R4]
            TBL_PAGE  <= tbl_phys & PAGE_MASK;  // [R4]
         end
         if (rd_pend) begin
            TBL_RDATA <= TBL_UPPER ? {8'h00, FLASH_DATA[23:16]} : FLASH_DATA[15:0];  // [R5]
         end
      end
   end

   // ---------------- register slave ----------------
   wire        aw_take   = AWVALID && AWREADY;
   wire        w_take    = WVALID && WREADY;
   wire        do_wr     = aw_held && w_held && !BVALID;
   wire        next_awh  = (aw_held || aw_take) && !do_wr;
   wire        next_wh   = (w_held || w_take) && !do_wr;
   wire        next_bv   = do_wr || (BVALID && !BREADY);
   wire        wr_map    = (aw_addr[31:4] == 28'h0000000) && (aw_addr[1:0] == 2'h0);
   wire        ar_take   = ARVALID && ARREADY;
   wire        next_rv   = ar_take || (RVALID && !RREADY);
   wire        rd_map    = (ARADDR[31:4] == 28'h0000000) && (ARADDR[1:0] == 2'h0);
   wire [31:0] ctrl_word = (32'(active) << P2_BIT) | 32'(cfg_q.mode);  // [R16]
   wire [31:0] seq_word  = {7'h00, reset_sel, eff2, eff1};
   wire [31:0] alternate_vector_table_word = {ALTERNATE_VECTOR_TABLE_EN, 7'h00, ALTERNATE_VECTOR_TABLE_BASE};
   wire [31:0] rd_mux    = (ARADDR == OFF_CTRL)   ? ctrl_word :
                           (ARADDR == OFF_TABLE_PAGE_REGISTER) ? {24'h000000, table_page_register} :
                           (ARADDR == OFF_SEQ)    ? seq_word :
                           (ARADDR == OFF_ALTERNATE_VECTOR_TABLE)   ? alternate_vector_table_word : 32'h00000000;

   always_ff @(posedge MCLK) begin
      if (RST) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 32'h00000000;
         w_data  <= 32'h00000000;
         w_strb  <= 4'h0;
         AWREADY <= 1'b0;
         WREADY  <= 1'b0;
         BVALID  <= 1'b0;
         BRESP   <= RESP_OKAY;
      end else begin
         aw_held <= next_awh;
         w_held  <= next_wh;
         AWREADY <= !next_awh && !next_bv;
         WREADY  <= !next_wh && !next_bv;
         BVALID  <= next_bv;
         if (aw_take) begin
            aw_addr <= AWADDR;
         end
         if (w_take) begin
            w_data <= WDATA;
            w_strb <= WSTRB;
         end
         if (do_wr) begin
            BRESP <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // table page steers every table access address
   always_ff @(posedge MCLK) begin
      if (RST) begin
         table_page_register <= TABLE_PAGE_REGISTER_RST;
      end else if (do_wr && aw_addr == OFF_TABLE_PAGE_REGISTER && w_strb[0]) begin
         table_page_register <= w_data[7:0];  // [R2]
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         ARREADY <= 1'b0;
         RVALID  <= 1'b0;
         RDATA   <= 32'h00000000;
         RRESP   <= RESP_OKAY;
      end else begin
         ARREADY <= !next_rv;
         RVALID  <= next_rv;
         if (ar_take) begin
            RDATA <= rd_mux;
            RRESP <= rd_map ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // ---------------- checks ----------------
   default clocking dpm_cb @(posedge MCLK);
   endclocking
   default disable iff (RST);

   sequence s_step_up;
      running && FETCH_OP == FOP_INC;
   endsequence

   sequence s_swap;
      do_swap ##1 1'b1;
   endsequence

   // both words intact or both corrupt, with equal values: the tie must pick partition one
   sequence s_resolve_eq;
      state == ST_RESOLVE && ok1 == ok2 && eff1 == eff2;
   endsequence

   AST_FETCH_ALIGNED: assert property (FETCH_VALID |-> !FETCH_ADDR[0]) // [R6]
      else $error("fetch address not word aligned");

   AST_FETCH_STEP: assert property (s_step_up |=> ptr == $past(ptr) + 23'h000002) // [R6]
      else $error("fetch increment is not two");

   AST_FETCH_LOWER: assert property (FETCH_VALID && !dual_q |-> !FETCH_ADDR[23]) // [R2]
      else $error("fetch reached upper half");

   AST_NO_FETCH_EARLY: assert property (state != ST_RUN |=> !FETCH_VALID && !TBL_STROBE) // [R22]
      else $error("access before partition resolved");

   AST_SWAP_TOGGLE: assert property (s_swap |-> active != $past(active, 1) && $stable(reset_sel)) // [R15]
      else $error("swap did not exchange partitions");

   AST_SINGLE_P1: assert property (running && !dual_q |-> !reset_sel && !active) // [R10]
      else $error("single mode left partition one");

   AST_EQUAL_P1: assert property (s_resolve_eq |=> !reset_sel) // [R12]
      else $error("equal sequences did not pick partition one");

   AST_ONE_BAD: assert property (state == ST_RESOLVE && dual_q && ok1 != ok2 |=> reset_sel == ok2) // [R13]
      else $error("intact partition not selected");

   AST_INACTIVE_ERR: assert property (fetch_go && dual_q |=> FETCH_ERR == $past(next_ptr[22])) // [R8]
      else $error("inactive partition fetch not flagged");

   AST_RESET_SEL_HELD: assert property (running && !$rose(running) |-> $stable(reset_sel)) // [R11]
      else $error("reset selection changed at run time");

   // the address was formed with the flag as it stood at the fetch edge
   AST_P2_FLAG_MAP: assert property (FETCH_VALID && dual_q && !FETCH_ERR |-> // [R9] [R16]
                                     FETCH_ADDR[22] == $past(active))
      else $error("active partition not at logical zero");

   AST_UPPER_BYTE_ZERO: assert property (TBL_RVALID && $past(TBL_UPPER) |-> TBL_RDATA[15:8] == 8'h00) // [R5]
      else $error("unimplemented upper byte not zero");

   AST_ROW_PAGE_ALIGNED: assert property (TBL_STROBE |-> (TBL_ROW & ~ROW_MASK) == 24'h000000 && // [R4]
                                          (TBL_PAGE & ~PAGE_MASK) == 24'h000000)
      else $error("row or page base not block aligned");

endmodule // dpm_program_map

/* File: hw/dpm_pkg.sv */
// package: constants and carrier types of the dual partition program map
package dpm_pkg;

   localparam int          ADDR_W            = 24;
   localparam int          PC_W              = 23;
   localparam logic [23:0] ACTIVE_BASE       = 24'h000000;
   localparam logic [23:0] INACTIVE_BASE     = 24'h400000;
   localparam logic [23:0] VECTOR_END        = 24'h000200;
   localparam logic [23:0] IVT_FIRST         = 24'h000004;
   localparam logic [23:0] IVT_LAST          = 24'h0000ff;
   localparam logic [23:0] ALTERNATE_VECTOR_TABLE_STEP         = 24'h000800;
   localparam logic [11:0] SEQ_MAX           = 12'hfff;
   localparam int          WRITE_BLOCK_WORDS = 128;
   localparam int          ERASE_BLOCK_WORDS = 1024;
   localparam int          ROW_LSB           = $clog2(WRITE_BLOCK_WORDS) + 1;
   localparam int          PAGE_LSB          = $clog2(ERASE_BLOCK_WORDS) + 1;
   localparam logic [23:0] ROW_MASK          = ~((24'h1 << ROW_LSB) - 24'h1);
   localparam logic [23:0] PAGE_MASK         = ~((24'h1 << PAGE_LSB) - 24'h1);
   localparam int          CFG_PAGE_BIT      = 7;
   localparam int          P2_BIT            = 10;

   localparam logic [31:0] OFF_CTRL          = 32'h00;
   localparam logic [31:0] OFF_TABLE_PAGE_REGISTER        = 32'h04;
   localparam logic [31:0] OFF_SEQ           = 32'h08;
   localparam logic [31:0] OFF_ALTERNATE_VECTOR_TABLE          = 32'h0c;
   localparam logic [7:0]  TABLE_PAGE_REGISTER_RST        = 8'h00;
   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_SLVERR       = 2'h2;

   typedef enum logic [1:0] {
      MODE_SINGLE    = 2'h0,
      MODE_DUAL      = 2'h1,
      MODE_DUAL_PROT = 2'h2
   } dpm_mode_t;

   typedef enum logic [1:0] {
      FOP_NONE = 2'h0,
      FOP_LOAD = 2'h1,
      FOP_INC  = 2'h2,
      FOP_DEC  = 2'h3
   } dpm_fop_t;

   typedef enum logic [2:0] {
      ST_LOAD    = 3'b001,
      ST_RESOLVE = 3'b010,
      ST_RUN     = 3'b100
   } dpm_state_t;

   typedef struct packed {
      logic [23:0] seq1;
      logic [23:0] seq2;
      logic        seq1_ok;
      logic        seq2_ok;
      dpm_mode_t   mode;
      logic [12:0] boot_segment_limit;
      logic        alternate_vector_table_dis;
   } dpm_cfg_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] offset;
   } dpm_tbl_t;

endpackage

/* File: dv/dpm_flash_model.sv */
// flash array model that answers the table reads of the program map
`timescale 1ns/10ps
module dpm_flash_model
   import dpm_pkg::*;
(
   input  wire logic        MCLK,
   input  wire logic        TBL_STROBE,
   input  wire logic [23:0] TBL_ADDR,
   output logic [23:0]      FLASH_DATA
);
   logic [23:0] last = 24'h000000;
   wire  [23:0] word = {TBL_ADDR[7:0] ^ 8'ha5, TBL_ADDR[15:0] ^ 16'h3c3c};

   // array output is only good while strobed; otherwise show the inverse of the last word
   assign FLASH_DATA = TBL_STROBE ? word : ~last;

   always_ff @(posedge MCLK) begin
      if (TBL_STROBE) begin
         last <= word;
      end
   end
endmodule // dpm_flash_model

/* File: dv/test_dpm_program_map.sv */
// self-checking bench of the program map: boot choice, swap, fetch, table and register access
`timescale 1ns/10ps
module test_dpm_program_map
   import dpm_pkg::*;
;
   logic        mclk, rst, cfg_done, swap;
   dpm_cfg_t    cfg;
   dpm_fop_t    fop;
   dpm_tbl_t    tbl;
   logic [22:0] fpc;
   logic [23:0] fdata, faddr, taddr, trow, tpage, alt_base;
   logic        fready, fvalid, ferr, fvec, fprim, fboot, tstb, twr, tcfg, tupper, trvalid, p2, alt_en;
   logic [15:0] trdata;
   logic [31:0] awaddr, wdata, araddr, rdata, rd;
   logic [3:0]  wstrb;
   logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0]  bresp, rresp, rs;
   int          err_count, checks_done;

   dpm_program_map uut (.MCLK(mclk), .RST(rst), .CFG(cfg), .CFG_DONE(cfg_done),
      .PARTITION_SWAP_INSTRUCTION(swap), .FETCH_OP(fop), .FETCH_PC(fpc), .TBL(tbl), .FLASH_DATA(fdata),
      .FETCH_READY(fready), .FETCH_VALID(fvalid), .FETCH_ADDR(faddr), .FETCH_ERR(ferr), .FETCH_VECTOR(fvec),
      .FETCH_IVT(fprim), .FETCH_BOOTSEG(fboot), .TBL_STROBE(tstb), .TBL_WR(twr), .TBL_ADDR(taddr),
      .TBL_CFG(tcfg), .TBL_UPPER(tupper), .TBL_ROW(trow), .TBL_PAGE(tpage), .TBL_RDATA(trdata),
      .TBL_RVALID(trvalid), .SECOND_PARTITION_ACTIVE_FLAG(p2), .ALTERNATE_VECTOR_TABLE_BASE(alt_base), .ALTERNATE_VECTOR_TABLE_EN(alt_en),
      .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
      .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));

   dpm_flash_model flash (.MCLK(mclk), .TBL_STROBE(tstb), .TBL_ADDR(taddr), .FLASH_DATA(fdata));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic results;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      bit aw, w;
      int n;
      aw = 0;
      w = 0;
      n = 0;
      @(posedge mclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hf;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw && w) && n < 50) begin
         @(posedge mclk);
         n++;
         if (!aw && awready === 1'b1) aw = 1;
         if (!w && wready === 1'b1) w = 1;
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      do begin
         @(posedge mclk);
         n++;
      end while (bvalid !== 1'b1 && n < 100);
      bready <= 1'b0;
      cmp("write response", 32'(er), 32'(bresp));
   endtask

   task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (arready !== 1'b1 && n < 50);
      arvalid <= 1'b0;
      do begin
         @(posedge mclk);
         n++;
      end while (rvalid !== 1'b1 && n < 100);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // a loader run needs a fresh reset, since the choice is only taken while loading
   task automatic boot(input int rc, input dpm_cfg_t c);
      int n;
      @(posedge mclk);
      rst <= 1'b1;
      cfg <= c;
      repeat (rc) @(posedge mclk);
      rst <= 1'b0;
      fop <= FOP_LOAD;
      tbl <= '{1'b1, 1'b0, 16'h0000};
      @(posedge mclk);
      fop <= FOP_NONE;
      tbl <= '0;
      #1 cmp("early fetch", 32'h0, 32'({fvalid, tstb}));
      cmp("flag after reset", 32'h0, 32'(p2));
      @(posedge mclk);
      cfg_done <= 1'b1;
      @(posedge mclk);
      cfg_done <= 1'b0;
      n = 0;
      while (fready !== 1'b1 && n < 20) begin
         @(posedge mclk);
         #1 n++;
      end
      cmp("fetch ready", 32'h1, 32'(fready));
      repeat (2) @(posedge mclk);
   endtask

   task automatic boot_chk(input int rc, input logic [23:0] s1, input logic [23:0] s2,
                           input logic o1, input logic o2, input dpm_mode_t m, input logic e);
      logic [11:0] e1, e2;
      e1 = (!o1 || s1[23:12] != 12'h000) ? 12'hfff : s1[11:0];
      e2 = (!o2 || s2[23:12] != 12'h000) ? 12'hfff : s2[11:0];
      boot(rc, '{s1, s2, o1, o2, m, 13'h0002, 1'b0});
      cmp("partition flag", 32'(e), 32'(p2));
      axi_rd(OFF_CTRL, rd, rs);
      cmp("ctrl", {21'h0, e, 8'h00, m}, rd);
      if (m != MODE_SINGLE) begin
         axi_rd(OFF_SEQ, rd, rs);
         cmp("seq", {7'h00, e, e2, e1}, rd);
      end
   endtask

   task automatic fetch(input dpm_fop_t o, input logic [22:0] pc, input logic [23:0] ea, input logic [3:0] ef);
      @(posedge mclk);
      fop <= o;
      fpc <= pc;
      @(posedge mclk);
      fop <= FOP_NONE;
      #1 cmp("fetch valid", 32'h1, 32'(fvalid));
      cmp("fetch addr", 32'(ea), 32'(faddr));
      cmp("fetch flags", 32'(ef), 32'({ferr, fvec, fprim, fboot}));
   endtask

   task automatic tblop(input logic w, input logic [15:0] off, input logic [23:0] ea, input logic tc);
      logic [23:0] fw;
      fw = {ea[7:0] ^ 8'ha5, ea[15:0] ^ 16'h3c3c};
      @(posedge mclk);
      tbl <= '{1'b1, w, off};
      @(posedge mclk);
      tbl <= '0;
      #1 cmp("table strobe", 32'h1, 32'(tstb));
      cmp("table addr", 32'(ea), 32'(taddr));
      cmp("table kind", 32'({w, tc, ea[0]}), 32'({twr, tcfg, tupper}));
      cmp("table row", 32'(ea & 24'hffff00), 32'(trow));
      cmp("table page", 32'(ea & 24'hfff800), 32'(tpage));
      if (!w) begin
         @(posedge mclk);
         #1 cmp("table rvalid", 32'h1, 32'(trvalid));
         cmp("table rdata", ea[0] ? {24'h0, fw[23:16]} : {16'h0, fw[15:0]}, 32'(trdata));
      end
   endtask

   task automatic pulse_swap;
      @(posedge mclk);
      swap <= 1'b1;
      @(posedge mclk);
      swap <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask

   initial begin
      repeat (5000) @(posedge mclk);
      err_count++;
      $display("mismatch watchdog expected done seen timeout");
      results();
   end

   initial begin
      err_count = 0;
      checks_done = 0;
      {rst, cfg_done, swap, fpc, awaddr, wdata, wstrb, awvalid, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
      rst = 1'b1;
      cfg = '0;
      tbl = '0;
      fop = FOP_NONE;
      repeat (16) @(posedge mclk);
      boot_chk(3, 24'h000005, 24'h000003, 1'b1, 1'b1, MODE_DUAL, 1'b1);
      @(posedge mclk);
      cfg <= '{24'h000001, 24'h000003, 1'b1, 1'b1, MODE_DUAL, 13'h0002, 1'b0};
      cfg_done <= 1'b1;
      @(posedge mclk);
      cfg_done <= 1'b0;
      repeat (3) @(posedge mclk);
      cmp("flag kept", 32'h1, 32'(p2));
      boot_chk(3, 24'h000001, 24'h000003, 1'b1, 1'b1, MODE_DUAL, 1'b0);
      boot_chk(3, 24'h000007, 24'h000007, 1'b1, 1'b1, MODE_DUAL_PROT, 1'b0);
      boot_chk(3, 24'h000001, 24'h000002, 1'b0, 1'b0, MODE_DUAL, 1'b0);
      boot_chk(3, 24'h001002, 24'h000fff, 1'b1, 1'b1, MODE_DUAL, 1'b1);
      boot_chk(3, 24'h000800, 24'h000001, 1'b1, 1'b0, MODE_DUAL, 1'b0);
      boot_chk(3, 24'h000005, 24'h000003, 1'b1, 1'b1, MODE_SINGLE, 1'b0);
      axi_rd(OFF_TABLE_PAGE_REGISTER, rd, rs);
      cmp("page reset value", 32'(TABLE_PAGE_REGISTER_RST), rd);
      fetch(FOP_LOAD, 23'h400000, 24'h400000, 4'b0000);
      pulse_swap();
      cmp("single swap", 32'h0, 32'(p2));
      boot_chk(3, 24'h000003, 24'h000005, 1'b1, 1'b1, MODE_DUAL, 1'b0);
      fetch(FOP_LOAD, 23'h000101, 24'h000100, 4'b0100);
      fetch(FOP_INC, 23'h000000, 24'h000102, 4'b0100);
      fetch(FOP_DEC, 23'h000000, 24'h000100, 4'b0100);
      fetch(FOP_LOAD, 23'h000002, 24'h000002, 4'b0100);
      fetch(FOP_LOAD, 23'h000004, 24'h000004, 4'b0110);
      fetch(FOP_LOAD, 23'h0000fe, 24'h0000fe, 4'b0110);
      fetch(FOP_LOAD, 23'h000200, 24'h000200, 4'b0001);
      fetch(FOP_LOAD, 23'h000ffe, 24'h000ffe, 4'b0001);
      fetch(FOP_LOAD, 23'h001000, 24'h001000, 4'b0000);
      fetch(FOP_LOAD, 23'h400000, 24'h400000, 4'b1000);
      cmp("alternate base", 32'h800, 32'(alt_base));
      axi_rd(OFF_ALTERNATE_VECTOR_TABLE, rd, rs);
      cmp("alternate reg", 32'h80000800, rd);
      pulse_swap();
      cmp("swapped flag", 32'h1, 32'(p2));
      axi_rd(OFF_SEQ, rd, rs);
      cmp("reset choice kept", 32'h0, 32'(rd[24]));
      fetch(FOP_LOAD, 23'h000200, 24'h400200, 4'b0001);
      fetch(FOP_LOAD, 23'h400002, 24'h000002, 4'b1000);
      tblop(1'b0, 16'h1235, 24'h401235, 1'b0);
      axi_wr(OFF_TABLE_PAGE_REGISTER, 32'h40, RESP_OKAY);
      tblop(1'b0, 16'h1234, 24'h001234, 1'b0);
      axi_wr(OFF_TABLE_PAGE_REGISTER, 32'h80, RESP_OKAY);
      tblop(1'b1, 16'h07fe, 24'h8007fe, 1'b1);
      tblop(1'b0, 16'h07ff, 24'h8007ff, 1'b1);
      axi_rd(OFF_TABLE_PAGE_REGISTER, rd, rs);
      cmp("page readback", 32'h80, rd);
      axi_wr(OFF_CTRL, 32'h0, RESP_OKAY);
      axi_rd(OFF_CTRL, rd, rs);
      cmp("ctrl read only", 32'h401, rd);
      axi_wr(32'h10, 32'h1, RESP_SLVERR);
      axi_rd(32'h10, rd, rs);
      cmp("unmapped read", {30'h0, RESP_SLVERR}, {rd[29:0], rs});
      axi_rd(32'h2, rd, rs);
      cmp("misaligned read", 32'(RESP_SLVERR), 32'(rs));
      boot(3, '{24'h3, 24'h5, 1'b1, 1'b1, MODE_DUAL, 13'h0000, 1'b0});
      cmp("no boot segment", 32'h0, 32'({alt_en, alt_base}));
      fetch(FOP_LOAD, 23'h000200, 24'h000200, 4'b0000);
      results();
   end
endmodule // test_dpm_program_map
